// >>> logic/fees_buf2.sv
// Small valid/ready buffer for received bits
// Assumes one clock and a synchronous active-high reset
module fees_buf2 #(
    parameter int W     = 1,
    parameter int DEPTH = 2
) (
    input  wire logic         mclk_in,    // Clock
    input  wire logic         reset_in,   // Sync reset, high
    input  wire logic         clr_in,     // Flush contents
    input  wire logic         s_valid_in, // Fill side valid
    output logic              s_ready_out,// Fill side ready
    input  wire logic [W-1:0] s_data_in,  // Fill side data
    output logic              m_valid_out,// Drain side valid
    input  wire logic         m_ready_in, // Drain side ready
    output logic [W-1:0]      m_data_out  // Drain side data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign s_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign m_valid_out = (cnt_q != '0);
    assign m_data_out  = mem_q[rp_q];
    assign push        = s_valid_in && s_ready_out;
    assign pop         = m_valid_out && m_ready_in;

    always_ff @(posedge mclk_in)
    begin
        if (push)
        begin
            mem_q[wp_q] <= s_data_in;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (reset_in || clr_in)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ==========================================================
    // Checks
    chk_no_overfill: assert property (@(posedge mclk_in) disable iff (reset_in)
        !s_ready_out |=> cnt_q == (AW+1)'(DEPTH) || $past(pop) || $past(clr_in))
        else $error("buffer count dropped without a pop");
endmodule

// >>> logic/fees_consts.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the estimator/synchronizer top and from its bench
`ifndef FEES_CONSTS_SVH
`define FEES_CONSTS_SVH

// ==========================================================
// Register offsets
`define FEES_ADDR_FILTER   7'h01
`define FEES_ADDR_SYNCSEL  7'h06
`define FEES_ADDR_RATEREF  7'h07
`define FEES_ADDR_FEECTL   7'h15
`define FEES_ADDR_FEERES   7'h16

// ==========================================================
// Field positions
`define FEES_SYNC_EXP_HI   3
`define FEES_SYNC_EXP_LO   1
`define FEES_RATE_EXP_TOP  0
`define FEES_RATE_EXP_HI   7
`define FEES_RATE_EXP_LO   6
`define FEES_REFK_HI       5
`define FEES_MODE_HI       1
`define FEES_LEN_HI        3
`define FEES_LEN_LO        2

// ==========================================================
// Reset values and fixed read bits
`define FEES_FILTER_RST    4'h0
`define FEES_FILTER_FIXED  4'h8
`define FEES_SYNCSEL_RST   4'h0
`define FEES_RATEREF_RST   8'h01
`define FEES_FEECTL_RST    4'h0

// ==========================================================
// Timing counts
`define FEES_PRESCALE_FULL 7'h7F
`define FEES_SPAN_BASE     7'h08
`define FEES_OVERSAMPLE    16
`define FEES_SAMPLE_PHASE  4'h8
`define FEES_LOCK_BITS     22

`endif

// >>> logic/fees_pkg.sv
// Types used by the frequency error estimator
// Assumes nothing of its surroundings
package fees_pkg;

    // ==========================================================
    // Estimator counting modes
    typedef enum logic [1:0]
    {
        FEES_MODE_OFF  = 2'h0,
        FEES_MODE_UP   = 2'h1,
        FEES_MODE_DN   = 2'h2,
        FEES_MODE_BOTH = 2'h3
    } fees_mode_t;

endpackage

// >>> logic/fees_top.sv
// Frequency error estimator and receive bit synchronizer
// Assumes mclk_in is the crystal-derived reference and inputs are synchronous
`include "fees_consts.svh"

// Notes on behaviour
// RQ1: Mode bits pick off, up, down, or both
// RQ2: Length bits set span 8, 16, 32, 64
// RQ3: Up pulse per one, down per zero
// RQ4: About twice modulation index pulses per symbol
// RQ5: Final 8-bit count readable, two's complement
// RQ6: Only down-counting modes give negative results
// RQ7: Counter wraps modulo 256 past signed range
// RQ8: Cleared at span start, held until next
// RQ9: Synchronizer runs in receive with enable set
// RQ10: Recovered clock runs at the bit rate
// RQ11: Data changes at recovered clock rising edge
// RQ12: Host samples on recovered clock falling edge
// RQ13: Host sets synchronizer clock sixteen times bit rate
// RQ14: Sync clock is crystal over divider times power
// RQ15: Six-bit divider 1..63 shared by clocks
// RQ16: Select fields at their documented bit positions
// RQ17: Lock reached within 22 received bits
// RQ18: Enable clear gives transparent data, no clock
module fees_top #(
    parameter int CNT_W = 8,
    parameter int PH_W  = 4
) (
    input  wire logic       mclk_in,                 // Reference clock
    input  wire logic       reset_in,                // Sync reset, high
    input  wire logic       reg_wr_in,               // Register write strobe
    input  wire logic [6:0] reg_addr_in,             // Register address
    input  wire logic [7:0] reg_wdata_in,            // Register write data
    output logic      [7:0] reg_rdata_out,           // Register read data
    input  wire logic       rx_mode_in,              // Receive mode active
    input  wire logic       sync_enable_in,          // Synchronous mode enable
    input  wire logic       demod_data_in,           // Demodulated data
    input  wire logic       up_pulse_in,             // Up pulse from demodulator
    input  wire logic       dn_pulse_in,             // Down pulse from demodulator
    input  wire logic       symbol_tick_in,          // One per received symbol
    input  wire logic       hold_in,                 // Receiver stall
    output logic            recovered_clock_pin_out, // Recovered data clock
    output logic            data_io_pin_out,         // Received data
    output logic            data_io_pin_oe_out,      // Data pin drive enable
    output logic            rate_tick_out,           // Bit-rate enable pulse
    output logic            sync_tick_out,           // Oversampling enable pulse
    output logic            bit_ready_out,           // Bit buffer can accept
    output logic            fee_busy_out             // Measurement running
);
    // ==========================================================
    // Helpers
    function automatic logic [6:0] pow_mask(input logic [2:0] e);
        pow_mask = `FEES_PRESCALE_FULL >> e;
    endfunction

    function automatic logic hit(input logic [6:0] c, input logic [2:0] e);
        hit = ((c & pow_mask(e)) == pow_mask(e));
    endfunction

    // ==========================================================
    // Register file
    logic [3:0]       filt_q;
    logic [3:0]       syncsel_q;
    logic [7:0]       rateref_q;
    logic [3:0]       feectl_q;
    logic [CNT_W-1:0] cnt_q;
    logic [6:0]       sym_q;
    logic             busy_q;
    logic [7:0]       rdata_q;
    logic             wr_ctl;

    assign wr_ctl = reg_wr_in && (reg_addr_in == `FEES_ADDR_FEECTL);

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            filt_q    <= `FEES_FILTER_RST;
            syncsel_q <= `FEES_SYNCSEL_RST;
            rateref_q <= `FEES_RATEREF_RST;
            feectl_q  <= `FEES_FEECTL_RST;
        end
        else if (reg_wr_in)
        begin
            // RQ16 select fields placement
            case (reg_addr_in)
                `FEES_ADDR_FILTER:  filt_q    <= reg_wdata_in[3:0];
                `FEES_ADDR_SYNCSEL: syncsel_q <= reg_wdata_in[3:0];
                `FEES_ADDR_RATEREF: rateref_q <= reg_wdata_in;
                `FEES_ADDR_FEECTL:  feectl_q  <= reg_wdata_in[3:0];
                default:            ;
            endcase
        end
    end

    // RQ5 result readback
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            case (reg_addr_in)
                `FEES_ADDR_FILTER:  rdata_q <= {`FEES_FILTER_FIXED, filt_q};
                `FEES_ADDR_SYNCSEL: rdata_q <= {4'h0, syncsel_q};
                `FEES_ADDR_RATEREF: rdata_q <= rateref_q;
                `FEES_ADDR_FEECTL:  rdata_q <= {4'h0, feectl_q};
                `FEES_ADDR_FEERES:  rdata_q <= 8'(cnt_q);
                default:            rdata_q <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out = rdata_q;

    // ==========================================================
    // Frequency error estimator
    fees_pkg::fees_mode_t mode;
    logic [6:0]           span;
    logic                 last_sym;
    logic                 cnt_up;
    logic                 cnt_dn;

    assign mode = fees_pkg::fees_mode_t'(feectl_q[`FEES_MODE_HI:0]);
    // RQ2 span of 8 shifted by length code
    assign span = `FEES_SPAN_BASE << feectl_q[`FEES_LEN_HI:`FEES_LEN_LO];
    assign last_sym = symbol_tick_in && ((sym_q + 7'h01) == span);
    // RQ1 mode gates which pulses count
    // RQ6 only down-counting modes decrement
    assign cnt_up = up_pulse_in && (mode == fees_pkg::FEES_MODE_UP
                                    || mode == fees_pkg::FEES_MODE_BOTH);
    assign cnt_dn = dn_pulse_in && (mode == fees_pkg::FEES_MODE_DN
                                    || mode == fees_pkg::FEES_MODE_BOTH);

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            busy_q <= 1'b0;
            sym_q  <= 7'h00;
        end
        // RQ8 new span starts on control write
        else if (wr_ctl)
        begin
            busy_q <= (reg_wdata_in[`FEES_MODE_HI:0] != 2'h0);
            sym_q  <= 7'h00;
        end
        else if (busy_q && symbol_tick_in)
        begin
            sym_q <= sym_q + 7'h01;
            // RQ2 stop after span symbols
            if (last_sym)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    // Width covers 2x modulation index pulses per symbol over the span
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            cnt_q <= '0;
        end
        // RQ8 clear at start of each span
        else if (wr_ctl)
        begin
            cnt_q <= '0;
        end
        // RQ3 up for ones, down for zeros
        // RQ4 counter sized for pulse rate
        // RQ7 plain modulo wrap, no saturation
        else if (busy_q && (cnt_up != cnt_dn))
        begin
            cnt_q <= cnt_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
        end
    end

    assign fee_busy_out = busy_q;

    // ==========================================================
    // Shared reference divider and prescaler
    logic [5:0] ref_k;
    logic [5:0] refcnt_q;
    logic [6:0] pre_q;
    logic       ref_tick;
    logic [2:0] sync_exp;
    logic [2:0] rate_exp;

    // RQ15 zero treated as one to keep the divider alive
    assign ref_k    = (rateref_q[`FEES_REFK_HI:0] == 6'h00) ? 6'h01
                                                            : rateref_q[`FEES_REFK_HI:0];
    assign ref_tick = (refcnt_q >= ref_k - 6'h01);
    assign sync_exp = syncsel_q[`FEES_SYNC_EXP_HI:`FEES_SYNC_EXP_LO];
    assign rate_exp = {syncsel_q[`FEES_RATE_EXP_TOP],
                       rateref_q[`FEES_RATE_EXP_HI:`FEES_RATE_EXP_LO]};

    // RQ15 one divider feeds all rates
    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            refcnt_q <= 6'h00;
            pre_q    <= 7'h00;
        end
        else if (ref_tick)
        begin
            refcnt_q <= 6'h00;
            pre_q    <= pre_q + 7'h01;
        end
        else
        begin
            refcnt_q <= refcnt_q + 6'h01;
        end
    end

    // RQ14 divide by two to the power seven minus select
    assign sync_tick_out = ref_tick && hit(pre_q, sync_exp);
    assign rate_tick_out = ref_tick && hit(pre_q, rate_exp);

    // ==========================================================
    // Bit synchronizer
    logic            sync_on;
    logic [PH_W-1:0] ph_q;
    logic            prev_q;
    logic            edge_seen;
    logic            late;
    logic            early;
    logic            buf_valid;
    logic            buf_data;
    logic            push;
    logic            pop;
    logic            clk_q;
    logic            data_q;

    // RQ9 only in receive with enable set
    assign sync_on   = rx_mode_in && sync_enable_in;
    assign edge_seen = sync_tick_out && (demod_data_in != prev_q);
    assign late      = edge_seen && (ph_q != '0) && (ph_q < PH_W'(`FEES_SAMPLE_PHASE));
    assign early     = edge_seen && (ph_q > PH_W'(`FEES_SAMPLE_PHASE))
                                 && (ph_q != '1);
    // RQ13 sixteen phases per bit assumed
    assign push      = sync_on && sync_tick_out && (ph_q == PH_W'(`FEES_SAMPLE_PHASE));
    // RQ10 one rising clock per bit slot
    assign pop       = sync_on && sync_tick_out && (ph_q == '0) && !hold_in && buf_valid;

    // RQ17 one-step nudge per edge bounds lock time
    always_ff @(posedge mclk_in)
    begin
        if (reset_in || !sync_on)
        begin
            ph_q   <= '0;
            prev_q <= 1'b0;
        end
        else if (sync_tick_out)
        begin
            prev_q <= demod_data_in;
            if (early)
            begin
                ph_q <= ph_q + PH_W'(2);
            end
            else if (!late)
            begin
                ph_q <= ph_q + 1'b1;
            end
        end
    end

    // Two entries let a short receiver stall pass without losing a bit
    fees_buf2 #(
        .W     (1),
        .DEPTH (2)
    ) u_buf (
        .mclk_in     (mclk_in),
        .reset_in    (reset_in),
        .clr_in      (!sync_on),
        .s_valid_in  (push),
        .s_ready_out (bit_ready_out),
        .s_data_in   (demod_data_in),
        .m_valid_out (buf_valid),
        .m_ready_in  (pop),
        .m_data_out  (buf_data)
    );

    always_ff @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            clk_q  <= 1'b0;
            data_q <= 1'b0;
        end
        // RQ18 transparent path, clock parked low
        else if (!sync_on)
        begin
            clk_q  <= 1'b0;
            data_q <= demod_data_in;
        end
        // RQ11 data and rising clock move together
        else if (pop)
        begin
            clk_q  <= 1'b1;
            data_q <= buf_data;
        end
        // RQ12 falling edge mid-slot for host sampling
        else if (sync_tick_out && ph_q == PH_W'(`FEES_SAMPLE_PHASE))
        begin
            clk_q <= 1'b0;
        end
    end

    assign recovered_clock_pin_out = clk_q;
    assign data_io_pin_out         = data_q;
    assign data_io_pin_oe_out      = rx_mode_in;

    // ==========================================================
    // Checks
    sequence s_start;
        wr_ctl && reg_wdata_in[`FEES_MODE_HI:0] != 2'h0;
    endsequence

    sequence s_ref_two;
        !ref_tick ##1 ref_tick;
    endsequence

    chk_mode_off_idle: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ1
        !busy_q && !wr_ctl |=> cnt_q == $past(cnt_q))
        else $error("count moved outside a measurement");
    chk_up_increment: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ3
        busy_q && !wr_ctl && mode == fees_pkg::FEES_MODE_UP && up_pulse_in
        |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("up pulse not counted");
    chk_down_decrement: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ6
        busy_q && !wr_ctl && mode == fees_pkg::FEES_MODE_DN && dn_pulse_in
        |=> cnt_q == $past(cnt_q) - 1'b1)
        else $error("down pulse not subtracted");
    chk_span_end: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ2
        busy_q && !wr_ctl && last_sym |=> !busy_q)
        else $error("measurement ran past its span");
    chk_start_clear: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ8
        s_start |=> cnt_q == '0 && busy_q && sym_q == 7'h00)
        else $error("measurement start did not clear");
    chk_wrap_low: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ7
        busy_q && !wr_ctl && cnt_dn && !cnt_up && cnt_q == CNT_W'(8'h80)
        |=> cnt_q == CNT_W'(8'h7F))
        else $error("count did not wrap past the low end");
    chk_data_at_rise: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ11
        sync_on && $past(sync_on) && $changed(data_q) |-> $rose(clk_q))
        else $error("data changed away from clock rise");
    chk_transparent: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ18
        !sync_on |=> !clk_q && data_q == $past(demod_data_in))
        else $error("transparent mode not honoured");
    chk_ref_period: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ15
        ref_tick && ref_k == 6'h02 && $stable(ref_k) && !reg_wr_in |=> s_ref_two)
        else $error("divider period wrong");
    chk_sync_rate: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ14
        sync_tick_out && ref_k == 6'h02 && sync_exp == 3'h6 && !reg_wr_in
        ##1 !reg_wr_in [*3] |-> !sync_tick_out ##1 sync_tick_out)
        else $error("sync tick off the divider");
    chk_phase_nudge: assert property (@(posedge mclk_in) disable iff (reset_in) // RQ17
        sync_on && late && !reset_in |=> ph_q == $past(ph_q))
        else $error("late edge did not hold the phase");
endmodule

// >>> test/fees_host_model.sv
// Host stand-in on the recovered clock and data pins
// Assumes a single reference clock; samples the pins once per reference cycle
module fees_host_model (
    input  wire logic        mclk_in,       // Reference clock
    input  wire logic        reset_in,      // Sync reset, high
    input  wire logic        clk_pin_in,    // Recovered data clock
    input  wire logic        data_pin_in,   // Received data pin
    input  wire logic        stall_in,      // Bench asks for a stall
    input  wire logic        chk_en_in,     // Edge checking on
    output logic             hold_out,      // Stall towards the block
    output logic             last_bit_out,  // Last bit taken
    output logic [15:0]      bit_count_out, // Bits taken so far
    output logic [7:0]       period_out,    // Cycles between clock rises
    output logic [7:0]       edge_err_out   // Data moves outside a rise
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_q;
    logic       data_q;
    logic [7:0] gap_q;

    always @(posedge mclk_in)
    begin
        if (reset_in)
        begin
            clk_q <= 1'b0;
            data_q <= 1'b0;
            gap_q <= 8'h00;
            hold_out <= 1'b0;
            last_bit_out <= 1'b0;
            bit_count_out <= 16'h0000;
            period_out <= 8'h00;
            edge_err_out <= 8'h00;
        end
        else
        begin
            clk_q <= clk_pin_in;
            data_q <= data_pin_in;
            gap_q <= gap_q + 8'h01;
            // Stall follows the bench one reference cycle later, on any cycle
            hold_out <= stall_in;
            if (clk_q && !clk_pin_in)
            begin
                last_bit_out <= data_pin_in;
                bit_count_out <= bit_count_out + 16'h0001;
            end
            if (clk_pin_in && !clk_q)
            begin
                period_out <= gap_q + 8'h01;
                gap_q <= 8'h00;
            end
            if (chk_en_in && data_pin_in !== data_q && !(clk_pin_in && !clk_q))
                edge_err_out <= edge_err_out + 8'h01;
        end
    end
endmodule

// >>> test/fees_top_tb_top.sv
// Self-checking bench for the estimator and bit synchronizer
// Assumes the design files and the host model are compiled before it
`include "fees_consts.svh"

module fees_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        reg_wr_in = 1'b0;
    logic [6:0]  reg_addr_in = 7'h00;
    logic [7:0]  reg_wdata_in = 8'h00;
    logic        rx_mode_in = 1'b0;
    logic        sync_enable_in = 1'b0;
    logic        demod_data_in = 1'b0;
    logic        up_pulse_in = 1'b0;
    logic        dn_pulse_in = 1'b0;
    logic        symbol_tick_in = 1'b0;
    logic        stall = 1'b0;
    logic        chk_en = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic        rclk, dpin, doe, rate_tick, sync_tick, bit_ready, busy, hold, last_bit;
    logic [15:0] nbits, nbits0;
    logic [7:0]  period, edge_err, g;
    int          fail_count = 0;
    int          comparisons = 0;
    int          i, j;

    logic [6:0]  r_a   [6] = '{`FEES_ADDR_FILTER, `FEES_ADDR_SYNCSEL, `FEES_ADDR_RATEREF,
                               `FEES_ADDR_FEECTL, `FEES_ADDR_FEERES, 7'h20};
    logic [7:0]  r_v   [6] = '{8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [3:0]  f_ctl [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h9, 4'hE};
    int          f_n   [6] = '{8, 8, 8, 16, 32, 64};
    int          f_u   [6] = '{3, 3, 3, 1, 1, 0};
    int          f_d   [6] = '{1, 1, 1, 2, 0, 3};
    logic [7:0]  f_exp [6] = '{8'h18, 8'hF8, 8'h10, 8'h10, 8'h20, 8'h40};
    logic [5:0]  t_k   [4] = '{6'h01, 6'h03, 6'h3F, 6'h02};
    logic [2:0]  t_se  [4] = '{3'h7, 3'h5, 3'h7, 3'h6};
    logic [2:0]  t_re  [4] = '{3'h4, 3'h6, 3'h6, 3'h3};
    logic [7:0]  t_sg  [4] = '{8'h01, 8'h0C, 8'h3F, 8'h04};
    logic [7:0]  t_rg  [4] = '{8'h08, 8'h06, 8'h7E, 8'h20};

    always #5 mclk_in = ~mclk_in;

    fees_top DUT (
        .mclk_in                 (mclk_in),
        .reset_in                (reset_in),
        .reg_wr_in               (reg_wr_in),
        .reg_addr_in             (reg_addr_in),
        .reg_wdata_in            (reg_wdata_in),
        .reg_rdata_out           (reg_rdata_out),
        .rx_mode_in              (rx_mode_in),
        .sync_enable_in          (sync_enable_in),
        .demod_data_in           (demod_data_in),
        .up_pulse_in             (up_pulse_in),
        .dn_pulse_in             (dn_pulse_in),
        .symbol_tick_in          (symbol_tick_in),
        .hold_in                 (hold),
        .recovered_clock_pin_out (rclk),
        .data_io_pin_out         (dpin),
        .data_io_pin_oe_out      (doe),
        .rate_tick_out           (rate_tick),
        .sync_tick_out           (sync_tick),
        .bit_ready_out           (bit_ready),
        .fee_busy_out            (busy)
    );

    fees_host_model host (
        .mclk_in       (mclk_in),
        .reset_in      (reset_in),
        .clk_pin_in    (rclk),
        .data_pin_in   (dpin),
        .stall_in      (stall),
        .chk_en_in     (chk_en),
        .hold_out      (hold),
        .last_bit_out  (last_bit),
        .bit_count_out (nbits),
        .period_out    (period),
        .edge_err_out  (edge_err)
    );

    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the address
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(negedge mclk_in);
        reg_addr_in = a;
        @(negedge mclk_in);
        check(reg_rdata_out, exp);
    endtask

    task automatic pulse(input logic u, input logic d, input logic t);
        @(negedge mclk_in);
        up_pulse_in = u;
        dn_pulse_in = d;
        symbol_tick_in = t;
        @(negedge mclk_in);
        up_pulse_in = 1'b0;
        dn_pulse_in = 1'b0;
        symbol_tick_in = 1'b0;
    endtask

    task automatic sym(input int nu, input int nd);
        repeat (nu) pulse(1'b1, 1'b0, 1'b0);
        repeat (nd) pulse(1'b0, 1'b1, 1'b0);
        pulse(1'b0, 1'b0, 1'b1);
    endtask

    // Sixteen reference cycles per bit with a tick every cycle
    task automatic bits(input logic b, input int n);
        @(negedge mclk_in);
        demod_data_in = b;
        repeat (16 * n - 1) @(negedge mclk_in);
    endtask

    // First gap after a change of divider may be short, so callers measure twice
    task automatic tick_gap(input bit rate, output logic [7:0] gap);
        int c;
        c = 0;
        while ((rate ? rate_tick : sync_tick) !== 1'b1 && c < 300)
        begin
            @(negedge mclk_in);
            c++;
        end
        c = 0;
        do
        begin
            @(negedge mclk_in);
            c++;
        end
        while ((rate ? rate_tick : sync_tick) !== 1'b1 && c < 300);
        gap = c[7:0];
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        repeat (4) @(negedge mclk_in);
        reset_in = 1'b0;
        for (i = 0; i < 6; i++)
            rd_chk(r_a[i], r_v[i]);
        wr(`FEES_ADDR_FILTER, 8'hFF);
        rd_chk(`FEES_ADDR_FILTER, 8'h8F);
        wr(`FEES_ADDR_FEERES, 8'h55);
        rd_chk(`FEES_ADDR_FEERES, 8'h00);
        wr(7'h20, 8'hAA);
        rd_chk(7'h20, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            wr(`FEES_ADDR_FEECTL, {4'h0, f_ctl[i]});
            repeat (f_n[i] - 1) sym(f_u[i], f_d[i]);
            check({7'h00, busy}, 8'h01);
            sym(f_u[i], f_d[i]);
            rd_chk(`FEES_ADDR_FEERES, f_exp[i]);
            check({7'h00, busy}, 8'h00);
            sym(2, 2);
            rd_chk(`FEES_ADDR_FEERES, f_exp[i]);
        end
        wr(`FEES_ADDR_FEECTL, 8'hFF);
        rd_chk(`FEES_ADDR_FEECTL, 8'h0F);
        wr(`FEES_ADDR_FEECTL, 8'h00);
        sym(2, 0);
        check({7'h00, busy}, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            wr(`FEES_ADDR_SYNCSEL, {4'h0, t_se[i], t_re[i][2]});
            wr(`FEES_ADDR_RATEREF, {t_re[i][1:0], t_k[i]});
            tick_gap(1'b0, g);
            tick_gap(1'b0, g);
            check(g, t_sg[i]);
            tick_gap(1'b1, g);
            tick_gap(1'b1, g);
            check(g, t_rg[i]);
        end
        rd_chk(`FEES_ADDR_SYNCSEL, 8'h0C);
        rd_chk(`FEES_ADDR_RATEREF, 8'hC2);
        wr(`FEES_ADDR_RATEREF, 8'h01);
        wr(`FEES_ADDR_SYNCSEL, 8'h0E);
        @(negedge mclk_in);
        rx_mode_in = 1'b1;
        sync_enable_in = 1'b1;
        chk_en = 1'b1;
        bits(1'b1, 24);
        check({7'h00, last_bit}, 8'h01);
        check(period, 8'h10);
        bits(1'b0, 24);
        check({7'h00, last_bit}, 8'h00);
        for (j = 0; j < 8; j++)
            bits(j[0], 1);
        check(period, 8'h10);
        stall = 1'b1;
        bits(1'b1, 1);
        nbits0 = nbits;
        bits(1'b0, 3);
        check({7'h00, bit_ready}, 8'h00);
        check(nbits[7:0], nbits0[7:0]);
        stall = 1'b0;
        j = 0;
        while (bit_ready !== 1'b1 && j < 100)
        begin
            @(negedge mclk_in);
            j++;
        end
        check({7'h00, bit_ready}, 8'h01);
        bits(1'b1, 2);
        check({7'h00, nbits != nbits0}, 8'h01);
        check(edge_err, 8'h00);
        sync_enable_in = 1'b0;
        chk_en = 1'b0;
        repeat (4) @(negedge mclk_in);
        for (j = 0; j < 4; j++)
        begin
            demod_data_in = j[0];
            @(negedge mclk_in);
            check({6'h00, rclk, dpin}, {7'h00, j[0]});
        end
        check({7'h00, doe}, 8'h01);
        rx_mode_in = 1'b0;
        sync_enable_in = 1'b1;
        for (j = 0; j < 40; j++)
        begin
            @(negedge mclk_in);
            check({6'h00, rclk, doe}, 8'h00);
        end
        give_verdict();
    end

    // Tests need under 10,000 cycles; this cuts a hang short
    initial
    begin
        #300_000;
        fail_count++;
        give_verdict();
    end
endmodule
